// ### rtl/ipm_master.v
/*
 host-side master for the controller's two-wire register port: one command
 writes a register or reads one back by dummy write and repeated start.
 assumes open-drain pins resolved outside; the slave does not stretch the clock.
*/
`timescale 1ns/1ns
`include "ipm_consts.vh"
module ipm_master #(
    parameter QUARTER_CYC = `IPM_QUARTER_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire cmd_read,
    input wire [2:0] cmd_strap_addr,
    input wire [7:0] cmd_reg_addr,
    input wire [7:0] cmd_wdata,
    output reg rsp_valid,
    output reg rsp_nack,
    output reg [7:0] rsp_rdata,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire interrupt_out_n,
    output wire irq_pending
);
    reg [15:0] div_cnt;
    reg tick;
    reg [1:0] phase;
    reg [1:0] state;
    reg [2:0] step;
    reg [3:0] bit_cnt;
    reg [7:0] shifter;
    reg op_read;
    reg [6:0] dev_addr;
    reg [7:0] reg_addr;
    reg [7:0] wdata;
    reg ack_ok;
    wire [1:0] pins_sync;
    wire sda_s;
    wire rx_byte;

    ipm_sync #(
        .WIDTH(2),
        .RESET_VAL(2'h3)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({interrupt_out_n, sda_in}),
        .sync_out(pins_sync)
    );

    assign sda_s = pins_sync[0];
    // a level, so irq_pending stays high as long as the slave holds interrupt_out_n low
    assign irq_pending = ~pins_sync[1];
    assign cmd_ready = (state == `IPM_ST_IDLE) && !rsp_valid;
    assign rx_byte = (step == `IPM_STEP_RDATA);

    // quarter-bit enable; held at zero while idle so a frame starts clean
    always @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (state == `IPM_ST_IDLE) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (div_cnt == QUARTER_CYC[15:0] - 16'h0001) begin
            div_cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            phase <= 2'h0;
            state <= `IPM_ST_IDLE;
            step <= `IPM_STEP_ADDR_WR;
            bit_cnt <= 4'h0;
            shifter <= 8'h00;
            op_read <= 1'b0;
            dev_addr <= 7'h00;
            reg_addr <= 8'h00;
            wdata <= 8'h00;
            ack_ok <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_nack <= 1'b0;
            rsp_rdata <= 8'h00;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                `IPM_ST_IDLE: begin
                    phase <= 2'h0;
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    if (cmd_valid && cmd_ready) begin
                        // slave holds its strap bits fixed, the host just mirrors them
                        dev_addr <= {`IPM_ADDR_FIXED, cmd_strap_addr};
                        reg_addr <= cmd_reg_addr;
                        wdata <= cmd_wdata;
                        op_read <= cmd_read;
                        step <= `IPM_STEP_ADDR_WR;
                        rsp_nack <= 1'b0;
                        state <= `IPM_ST_START;
                    end
                end
                `IPM_ST_START: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: sda_oe <= 1'b0;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b1;
                        default: begin
                            scl_oe <= 1'b1;
                            bit_cnt <= 4'h0;
                            // address first, direction in bit zero
                            if (step == `IPM_STEP_ADDR_RD) begin
                                shifter <= {dev_addr, `IPM_DIR_READ};
                            end else begin
                                shifter <= {dev_addr, `IPM_DIR_WRITE};
                            end
                            state <= `IPM_ST_BYTE;
                        end
                    endcase
                end
                `IPM_ST_BYTE: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: begin
                            // data moves only with the clock held low
                            if (bit_cnt != `IPM_ACK_SLOT) begin
                                sda_oe <= rx_byte ? 1'b0 : ~shifter[7];
                            end else begin
                                // release for the slave's ack, or ack its read byte
                                sda_oe <= rx_byte;
                            end
                        end
                        2'h1: scl_oe <= 1'b0;
                        2'h2: begin
                            if (bit_cnt != `IPM_ACK_SLOT) begin
                                if (rx_byte) begin
                                    shifter <= {shifter[6:0], sda_s};
                                end
                            end else begin
                                ack_ok <= rx_byte | ~sda_s;
                            end
                        end
                        default: begin
                            scl_oe <= 1'b1;
                            if (bit_cnt != `IPM_ACK_SLOT) begin
                                bit_cnt <= bit_cnt + 4'h1;
                                if (!rx_byte) begin
                                    shifter <= {shifter[6:0], 1'b0};
                                end
                            end else begin
                                bit_cnt <= 4'h0;
                                if (!ack_ok) begin
                                    // no answer: close the frame and report
                                    rsp_nack <= 1'b1;
                                    state <= `IPM_ST_STOP;
                                end else begin
                                    case (step)
                                        `IPM_STEP_ADDR_WR: begin
                                            step <= `IPM_STEP_REG;
                                            shifter <= reg_addr;
                                        end
                                        `IPM_STEP_REG: begin
                                            if (op_read) begin
                                                // pointer set, turn around without a stop
                                                step <= `IPM_STEP_ADDR_RD;
                                                state <= `IPM_ST_START;
                                            end else begin
                                                step <= `IPM_STEP_WDATA;
                                                shifter <= wdata;
                                            end
                                        end
                                        `IPM_STEP_ADDR_RD: begin
                                            step <= `IPM_STEP_RDATA;
                                        end
                                        `IPM_STEP_RDATA: begin
                                            rsp_rdata <= shifter;
                                            state <= `IPM_ST_STOP;
                                        end
                                        default: state <= `IPM_ST_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                `IPM_ST_STOP: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: sda_oe <= 1'b1;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b0;
                        default: begin
                            rsp_valid <= 1'b1;
                            state <= `IPM_ST_IDLE;
                        end
                    endcase
                end
                default: state <= `IPM_ST_IDLE;
            endcase
        end
    end
endmodule // ipm_master

// ### rtl/ipm_consts.vh
/*
 constants for the host-side two-wire master that talks to the
 power-management controller's serial register port.
 assumes a 50 mhz system clock and a slave with sixteen byte registers.
*/
// Contract
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock low
// - bytes are eight bits, msb first
// - ninth clock: sender releases, receiver pulls low
// - data high in ack clock means nack
// - master acks every read data byte
// - first byte is address plus direction bit
// - direction in bit zero, low means write
// - reads use repeated start, not stop
// - write sends register address then data
// - read: dummy write, repeated start, read
`ifndef IPM_CONSTS_VH
`define IPM_CONSTS_VH

`define IPM_CLK_HZ 50000000
`define IPM_SCL_HZ 100000
`define IPM_QUARTER_CYC ((`IPM_CLK_HZ / `IPM_SCL_HZ) / 4)

`define IPM_ADDR_FIXED 4'h4
`define IPM_DIR_READ 1'b1
`define IPM_DIR_WRITE 1'b0
`define IPM_REG_ADDR_MAX 8'h0f

`define IPM_ST_IDLE 2'h0
`define IPM_ST_START 2'h1
`define IPM_ST_BYTE 2'h2
`define IPM_ST_STOP 2'h3

`define IPM_STEP_ADDR_WR 3'h0
`define IPM_STEP_REG 3'h1
`define IPM_STEP_WDATA 3'h2
`define IPM_STEP_ADDR_RD 3'h3
`define IPM_STEP_RDATA 3'h4

`define IPM_ACK_SLOT 4'h8

`endif

// ### rtl/ipm_sync.v
/*
 two flip-flop synchroniser for pins arriving from outside the clock domain.
 assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ns
module ipm_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // first stage feeds only the second
    always @(posedge clk) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // ipm_sync

// ### verif/ipm_master_assertions.sv
/* port checker for the two-wire master.
 assumes QUARTER_CYC of 4 and open-drain pins resolved by the bench. */
`timescale 1ns/1ns
module ipm_master_assertions (
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire scl_oe,
    input wire sda_oe,
    input wire interrupt_out_n,
    input wire irq_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence clk_low_s;
        ##[2:6] scl_oe;
    endsequence
    sequence stop_done_s;
        ##[1:8] rsp_valid;
    endsequence
    bus_free_reset_a: assert property ($rose(rst_n) |-> !scl_oe && !sda_oe && !rsp_valid)
        else $error("bus not released after reset");
    sda_skew_a: assert property ($changed(sda_oe) |-> $stable(scl_oe))
        else $error("data and clock moved together");
    start_cond_a: assert property ($rose(sda_oe) && !scl_oe |-> clk_low_s)
        else $error("start not followed by clock low");
    stop_cond_a: assert property ($fell(sda_oe) && !scl_oe |-> stop_done_s)
        else $error("stop not followed by response");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    // a transfer lasts hundreds of cycles, so eight refused cycles is a safe floor
    busy_refuse_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*8])
        else $error("command taken while busy");
    scl_low_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
        else $error("clock low phase too short");
    irq_follow_a: assert property (!interrupt_out_n [*4] |-> irq_pending)
        else $error("interrupt not seen");
    irq_clear_a: assert property (interrupt_out_n [*4] |-> !irq_pending)
        else $error("interrupt stuck");
endmodule // ipm_master_assertions
bind ipm_master ipm_master_assertions u_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .interrupt_out_n(interrupt_out_n), .irq_pending(irq_pending));

// ### verif/ipm_dev_model.sv
/* behavioural slave port with sixteen byte registers.
 assumes the wire levels are resolved by the bench; no clock stretching. */
`timescale 1ns/1ns
module ipm_dev_model #(
    parameter [2:0] STRAP = 3'h5
) (
    input wire scl,
    input wire sda,
    input wire sw_mode,
    output reg sda_oe
);
    // plain storage: a read returns the last write at once, well inside the pin limit
    reg [7:0] regs [0:15];
    reg [7:0] sh = 8'h00;
    reg [7:0] tx = 8'h00;
    reg [3:0] bc = 4'h0;
    reg [1:0] ph = 2'h0;
    reg [3:0] ptr = 4'h0;
    reg act = 1'b0;
    integer i;
    initial begin
        sda_oe = 1'b0;
        for (i = 0; i < 16; i = i + 1) regs[i] = 8'h00;
    end
    always @(negedge sda) if (scl) begin
        bc = 4'hf;
        ph = 2'h0;
        act = sw_mode;
        sda_oe = 1'b0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act && bc < 8) sh = {sh[6:0], sda};
    always @(negedge scl) if (act) begin
        bc = bc + 4'h1;
        sda_oe = 1'b0;
        if (bc == 9) begin
            bc = 4'h0;
            if (ph == 3) sda_oe = ~tx[7];
        end else if (bc == 8 && ph == 0) begin
            act = sh[7:1] == {4'h4, STRAP};
            sda_oe = act;
            ph = sh[0] ? 2'h3 : 2'h1;
            tx = regs[ptr];
        end else if (bc == 8 && ph == 3) begin
            // one byte per read; stay off the line so the stop can pass
            act = 1'b0;
        end else if (bc == 8) begin
            if (ph == 1) ptr = sh[3:0];
            else regs[ptr] = sh;
            ph = 2'h2;
            sda_oe = 1'b1;
        end else if (ph == 3) sda_oe = ~tx[7 - bc];
    end
endmodule // ipm_dev_model

// ### verif/test_ipm_master.sv
/* self-checking bench for the two-wire master against a slave model.
 assumes QUARTER_CYC of 4 so each transfer takes a few hundred cycles. */
`timescale 1ns/1ns
module test_ipm_master;
    localparam [2:0] STRAP = 3'h5;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg cmd_valid = 1'b0;
    reg cmd_read = 1'b0;
    reg [2:0] cmd_strap_addr = 3'h0;
    reg [7:0] cmd_reg_addr = 8'h00;
    reg [7:0] cmd_wdata = 8'h00;
    reg sw_mode = 1'b1;
    reg int_n = 1'b1;
    wire cmd_ready, rsp_valid, rsp_nack, scl_out, scl_oe, sda_out, sda_oe, dev_oe, irq_pending;
    wire [7:0] rsp_rdata;
    wire scl = scl_oe ? scl_out : 1'b1;
    wire sda = (sda_oe ? sda_out : 1'b1) & ~dev_oe;
    reg [9:0] expq [$];
    reg [7:0] mem [0:15];
    reg [9:0] e;
    integer seed, mismatches = 0, n_checks = 0, r;
    always #10 clk = ~clk;
    ipm_master #(.QUARTER_CYC(4)) u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_strap_addr(cmd_strap_addr),
        .cmd_reg_addr(cmd_reg_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .interrupt_out_n(int_n),
        .irq_pending(irq_pending));
    ipm_dev_model #(.STRAP(STRAP)) u_dev (.scl(scl), .sda(sda), .sw_mode(sw_mode),
        .sda_oe(dev_oe));
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task check(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // e = {compare data, nack, data}
    task cmd(input rd, input [2:0] st, input [7:0] ra, input [7:0] wd, input [9:0] ex);
        integer i;
        begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_read = rd;
            cmd_strap_addr = st;
            cmd_reg_addr = ra;
            cmd_wdata = wd;
            expq.push_back(ex);
            for (i = 0; cmd_ready !== 1'b1; i = i + 1) begin
                if (i > 3000) begin
                    mismatches = mismatches + 1;
                    complete_run;
                end
                @(negedge clk);
            end
            @(negedge clk);
            cmd_valid = 1'b0;
        end
    endtask
    task drain(input [8*8-1:0] name);
        integer i;
        begin
            for (i = 0; expq.size() > 0; i = i + 1) begin
                if (i > 3000) begin
                    mismatches = mismatches + 1;
                    complete_run;
                end
                @(negedge clk);
            end
            $display("test %0s done", name);
        end
    endtask
    always @(negedge clk) if (rst_n && rsp_valid === 1'b1) begin
        if (expq.size() == 0) check(8'h01, 8'h00);
        else begin
            e = expq.pop_front();
            check({7'h00, rsp_nack}, {7'h00, e[8]});
            if (e[9]) check(rsp_rdata, e[7:0]);
        end
    end
    initial begin
        seed = 32'h9b8573ca;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({5'h00, scl_oe, sda_oe, cmd_ready}, 8'h01);
        // every register, written and read back to back
        for (r = 0; r < 16; r = r + 1) begin
            mem[r] = $random(seed);
            cmd(1'b0, STRAP, r[7:0], mem[r], 10'h000);
            cmd(1'b1, STRAP, r[7:0], 8'h00, {2'b10, mem[r]});
        end
        drain("rw_all");
        // another strap code must be ignored and leave the register alone
        cmd(1'b0, STRAP ^ 3'h1, 8'h02, 8'h5a, 10'h100);
        cmd(1'b1, ~STRAP, 8'h02, 8'h00, 10'h100);
        cmd(1'b1, STRAP, 8'h02, 8'h00, {2'b10, mem[2]});
        drain("strap");
        sw_mode = 1'b0;
        cmd(1'b0, STRAP, 8'h03, 8'hc3, 10'h100);
        drain("hw_mode");
        sw_mode = 1'b1;
        cmd(1'b1, STRAP, 8'h03, 8'h00, {2'b10, mem[3]});
        drain("sw_mode");
        int_n = 1'b0;
        repeat (5) @(negedge clk);
        check({7'h00, irq_pending}, 8'h01);
        int_n = 1'b1;
        repeat (5) @(negedge clk);
        check({7'h00, irq_pending}, 8'h00);
        $display("test irq done");
        complete_run;
    end
endmodule // test_ipm_master
